// File: common/rtu_pkg.sv
// Package for the return instruction unit: opcodes, widths, timing.
// Assumes a single 20 MHz core clock and one-byte-wide stack reads.
package rtu_pkg;
  localparam int RTU_CLK_HZ = 20_000_000;
  localparam int RTU_CLKS_PER_MC = 4;
  localparam logic [7:0] RTU_OP_SUB_RET = 8'h22;
  localparam logic [7:0] RTU_OP_INT_RET = 8'h32;
  localparam int RTU_MACHINE_CYCLES = 2;
  localparam logic [7:0] RTU_SP_RESET = 8'h07;
  localparam logic [15:0] RTU_PC_RESET = 16'h0000;
  localparam logic [1:0] RTU_MC_CNT_RESET = 2'h0;

  typedef enum logic [2:0] {
    RTU_IDLE,
    RTU_POP_HI,
    RTU_POP_LO,
    RTU_FINISH
  } rtu_state_t;
endpackage : rtu_pkg

// File: core/rtu_mc_tick.sv
// Machine cycle divider: one-cycle enable pulse every RTU_CLKS_PER_MC clocks.
// Assumes the core clock and reset of the surrounding core.
`timescale 1ns/1ps
module rtu_mc_tick #(
  parameter int DIV = 4
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Enable
  output logic o_tick
);
  import rtu_pkg::*;

  initial begin
    if (DIV < 2 || DIV > 256) begin
      $error("rtu_mc_tick: DIV out of range");
    end
  end

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } rtu_tick_state_t;

  rtu_tick_state_t s_q;
  rtu_tick_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 8'(DIV - 1)) begin
      s_d.cnt = 8'h00;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_tick = s_q.tick;
endmodule : rtu_mc_tick

// File: core/rtu_return_unit.sv
// Return instruction unit: executes subroutine return and interrupt return.
// Assumes the core presents one opcode with a start strobe, and a stack
// memory that returns the addressed byte combinationally in the same cycle.
//
// Summary of operation
// [RULE_01] Interrupt return pops program counter high byte first, then low byte.
// [RULE_02] Interrupt return re-arms interrupt acceptance at the serviced priority level.
// [RULE_03] Stack pointer ends at its starting value minus two, decrement after each pop.
// [RULE_04] Only program counter and stack pointer change; status word is never restored.
// [RULE_05] Fetch resumes at the address built from the two popped bytes.
// [RULE_06] A pending lower or equal interrupt waits for one more instruction; the code blocks any pending interrupt, with no level compare.
// [RULE_07] Subroutine return is one opcode byte and takes two machine cycles.
// [RULE_08] Opcode 0x22 is subroutine return, 0x32 is interrupt return.
`timescale 1ns/1ps
module rtu_return_unit (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Instruction issue
  input wire logic i_start,
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] i_stack_pointer,
  // Stack memory read
  input wire logic [7:0] i_stack_data,
  output logic [7:0] o_stack_addr,
  output logic o_stack_rd,
  // Interrupt controller
  input wire logic i_irq_pending,
  input wire logic i_instr_done,
  output logic o_int_rearm,
  output logic o_irq_block,
  // Results to the core
  output logic o_busy,
  output logic o_done,
  output logic o_illegal,
  output logic [15:0] o_program_counter,
  output logic [7:0] o_stack_pointer,
  output logic o_pc_load,
  output logic o_sp_load
);
  import rtu_pkg::*;

  typedef struct packed {
    rtu_state_t st;
    logic is_int;
    logic [1:0] mc;
    logic [7:0] sp;
    logic [15:0] pc;
    logic [7:0] addr;
    logic rd;
    logic rearm;
    logic block;
    logic busy;
    logic done;
    logic illegal;
    logic pc_load;
    logic sp_load;
  } rtu_regs_t;

  rtu_regs_t r_q;
  rtu_regs_t r_d;
  logic tick;

  // Decode of the two opcodes this unit owns; anything else is refused
  function automatic logic rtu_is_return(input logic [7:0] op);
    rtu_is_return = (op == RTU_OP_SUB_RET) || (op == RTU_OP_INT_RET);
  endfunction : rtu_is_return

  function automatic logic rtu_is_int_return(input logic [7:0] op);
    rtu_is_int_return = (op == RTU_OP_INT_RET);
  endfunction : rtu_is_int_return

  // Stack grows upward, so every pop steps the pointer down and wraps at zero
  function automatic logic [7:0] rtu_sp_dec(input logic [7:0] sp);
    rtu_sp_dec = sp - 8'h01;
  endfunction : rtu_sp_dec

  // The machine cycle counter is two bits wide
  initial begin
    if (RTU_MACHINE_CYCLES < 1 || RTU_MACHINE_CYCLES > 4) begin
      $error("rtu_return_unit: machine cycle count does not fit the counter");
    end
  end

  // Flow: IDLE takes the opcode, POP_HI reads the byte at the pointer,
  // POP_LO reads the byte one below, FINISH waits for the second machine
  // cycle tick and then publishes both results in one pulse. Results are
  // only loaded at the end so the core never sees a half-popped counter.

  rtu_mc_tick #(
    .DIV(RTU_CLKS_PER_MC)
  ) u_tick (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .o_tick(tick)
  );

  // The status word is not an input or output here at all, so it cannot change.
  always_comb begin // RULE_04
    r_d = r_q;
    r_d.done = 1'b0;
    r_d.illegal = 1'b0;
    r_d.rearm = 1'b0;
    r_d.pc_load = 1'b0;
    r_d.sp_load = 1'b0;
    r_d.rd = 1'b0;
    // Block lasts through the one following instruction
    if (r_q.block && i_instr_done && !r_q.busy) begin
      r_d.block = 1'b0; // RULE_06
    end
    case (r_q.st)
      RTU_IDLE: begin
        if (i_start) begin
          if (rtu_is_return(i_opcode)) begin // RULE_08
            r_d.is_int = rtu_is_int_return(i_opcode); // RULE_08
            r_d.sp = i_stack_pointer;
            r_d.addr = i_stack_pointer;
            r_d.busy = 1'b1;
            r_d.mc = RTU_MC_CNT_RESET;
            r_d.st = RTU_POP_HI;
          end else begin
            r_d.illegal = 1'b1;
          end
        end
      end
      RTU_POP_HI: begin
        // First read returns the high byte
        r_d.rd = 1'b1;
        r_d.pc[15:8] = i_stack_data; // RULE_01
        r_d.sp = rtu_sp_dec(r_q.sp); // RULE_03
        r_d.addr = rtu_sp_dec(r_q.sp);
        r_d.st = RTU_POP_LO;
      end
      RTU_POP_LO: begin
        r_d.rd = 1'b1;
        r_d.pc[7:0] = i_stack_data; // RULE_01
        r_d.sp = rtu_sp_dec(r_q.sp); // RULE_03
        r_d.st = RTU_FINISH;
      end
      RTU_FINISH: begin
        // Hold results until two machine cycles have elapsed
        if (tick) begin
          r_d.mc = r_q.mc + 2'h1;
        end
        if (tick && r_q.mc == 2'(RTU_MACHINE_CYCLES - 1)) begin // RULE_07
          r_d.st = RTU_IDLE;
          r_d.busy = 1'b0;
          r_d.done = 1'b1;
          r_d.pc_load = 1'b1; // RULE_05
          r_d.sp_load = 1'b1; // RULE_03
          if (r_q.is_int) begin
            r_d.rearm = 1'b1; // RULE_02
            r_d.block = i_irq_pending; // RULE_06
          end
        end
      end
      default: begin
        r_d.st = RTU_IDLE;
        r_d.busy = 1'b0;
      end
    endcase
    if (r_q.st != RTU_IDLE && r_q.st != RTU_FINISH && tick) begin
      r_d.mc = r_q.mc + 2'h1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_q <= '{st: RTU_IDLE, sp: RTU_SP_RESET, pc: RTU_PC_RESET,
               mc: RTU_MC_CNT_RESET, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign o_stack_addr = r_q.addr;
  assign o_stack_rd = r_q.rd;
  assign o_int_rearm = r_q.rearm;
  assign o_irq_block = r_q.block;
  assign o_busy = r_q.busy;
  assign o_done = r_q.done;
  assign o_illegal = r_q.illegal;
  assign o_program_counter = r_q.pc;
  assign o_stack_pointer = r_q.sp;
  assign o_pc_load = r_q.pc_load;
  assign o_sp_load = r_q.sp_load;
endmodule : rtu_return_unit

// File: bench/rtu_properties.sv
// Port checker for the return unit.
// Bound in tb_top; one clock, async low reset.
`timescale 1ns/1ps
module rtu_properties
  import rtu_pkg::*;
(
  // Clock, reset, issue
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] i_stack_pointer,
  input wire logic i_irq_pending,
  // Results
  input wire logic [7:0] o_stack_addr,
  input wire logic o_stack_rd,
  input wire logic o_irq_block,
  input wire logic o_int_rearm,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_illegal,
  input wire logic [7:0] o_stack_pointer,
  input wire logic o_pc_load
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] sp_q;
  logic [7:0] op_q;
  wire go = i_start && !o_busy;
  wire ok = i_opcode inside {RTU_OP_SUB_RET, RTU_OP_INT_RET};
  // Operands kept, since results are judged long after issue
  always_ff @(posedge i_clock) if (go) sp_q <= i_stack_pointer;
  always_ff @(posedge i_clock) if (go) op_q <= i_opcode;
  sequence s_pops;
    o_stack_addr == sp_q ##1 o_stack_addr == sp_q - 8'h01;
  endsequence
  AST_POP_ORDER: assert property (go && ok |=> o_busy ##0 s_pops)
    else $error("pop order");
  AST_TIMING: assert property (go && ok |-> ##[4:12] o_done)
    else $error("late");
  AST_SP_FINAL: assert property (o_done |-> o_stack_pointer == sp_q - 8'h02)
    else $error("sp");
  AST_PC_LOAD: assert property (o_done |-> o_pc_load)
    else $error("pc load");
  AST_REARM: assert property (o_done |-> o_int_rearm == (op_q == RTU_OP_INT_RET))
    else $error("rearm");
  AST_NO_STRAY: assert property (o_int_rearm || o_pc_load |-> o_done)
    else $error("stray");
  AST_ILLEGAL: assert property (go && !ok |=> o_illegal && !o_busy)
    else $error("illegal");
  AST_DECODE: assert property (go && ok |=> !o_illegal)
    else $error("decode");
  AST_READS: assert property (go && ok |=> !o_stack_rd ##1 o_stack_rd ##1 o_stack_rd)
    else $error("reads");
  AST_BLOCK: assert property (o_done && op_q == RTU_OP_INT_RET |-> o_irq_block == $past(i_irq_pending))
    else $error("block");
endmodule : rtu_properties

// File: bench/tb_top.sv
// Bench for the return unit: back-to-back returns, a bad opcode.
// Stack bytes are addr ^ A5, served in the same cycle.
`timescale 1ns/1ps
module tb_top;
  import rtu_pkg::*;
  logic i_clock = 0, i_rst_n = 0, st = 0, pend = 0, idn = 0;
  logic [7:0] op = 0, spi = 0, adr, sp;
  logic [15:0] pc;
  logic bsy, dn, ill, rea, blk, pcl, spl;
  int num_errors = 0;
  int cmp_count = 0;
  always #25 i_clock = ~i_clock;
  rtu_return_unit u_dut (.i_clock, .i_rst_n, .i_start(st), .i_opcode(op),
    .i_stack_pointer(spi), .i_stack_data(adr ^ 8'hA5), .o_stack_addr(adr),
    .o_stack_rd(), .i_irq_pending(pend), .i_instr_done(idn), .o_int_rearm(rea),
    .o_irq_block(blk), .o_busy(bsy), .o_done(dn), .o_illegal(ill),
    .o_program_counter(pc), .o_stack_pointer(sp), .o_pc_load(pcl), .o_sp_load(spl));
  task automatic chk(input logic c, input string m);
    cmp_count++;
    if (c !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic wrap_up;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic issue(input logic [7:0] o, input logic [7:0] s);
    int n;
    op = o;
    spi = s;
    st = 1;
    @(posedge i_clock) #1;
    st = 0;
    for (n = 0; n < 20 && dn !== 1'b1; n++) @(posedge i_clock) #1;
    chk(n < 20, "hang");
    if (n == 20) wrap_up();
    chk(spl && pc === {s ^ 8'hA5, (s - 8'h01) ^ 8'hA5}, "pc");
    chk(sp === s - 8'h02, "sp");
    chk(rea === (o == RTU_OP_INT_RET), "rearm");
  endtask : issue
  task automatic t_sub;
    issue(RTU_OP_SUB_RET, 8'h0B);
    chk(blk === 1'b0, "block");
  endtask : t_sub
  task automatic t_int;
    // Stack pointer 01 makes the final pointer wrap to FF
    pend = 1;
    issue(RTU_OP_INT_RET, 8'h01);
    chk(blk === 1'b1, "no block");
    @(posedge i_clock) #1;
    idn = 1;
    @(posedge i_clock) #1;
    idn = 0;
    pend = 0;
    chk(blk === 1'b0, "block stuck");
  endtask : t_int
  task automatic t_bad;
    op = 8'h00;
    st = 1;
    @(posedge i_clock) #1;
    st = 0;
    chk(ill === 1'b1 && bsy === 1'b0, "refuse");
  endtask : t_bad
  initial begin
    repeat (16) @(posedge i_clock);
    #1 i_rst_n = 1;
    t_sub();
    t_int();
    t_bad();
    wrap_up();
  end
endmodule : tb_top
bind rtu_return_unit rtu_properties u_chk (.*);
